/* rtl/prjs_pkg.sv */
// Shared constants and carrier types for the program run and jog sequencer
package prjs_pkg;
	// Register byte offsets
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_FILTER = 12'h004;
	localparam logic [11:0] OFF_JOG_SPEED = 12'h008;
	localparam logic [11:0] OFF_ACCEL = 12'h00C;
	localparam logic [11:0] OFF_DECEL = 12'h010;
	localparam logic [11:0] OFF_SCURVE = 12'h014;
	localparam logic [11:0] OFF_SOFT_MIN = 12'h018;
	localparam logic [11:0] OFF_SOFT_MAX = 12'h01C;
	localparam logic [11:0] OFF_STATUS = 12'h020;
	localparam logic [11:0] OFF_PROG_BASE = 12'h200;
	localparam logic [11:0] OFF_PROG_LAST = 12'h3FC;

	// Field positions
	localparam int CTRL_DIR_BIT = 0;
	localparam int STEP_OP_MSB = 31;
	localparam int STEP_OP_LSB = 28;
	localparam int STEP_ARG_MSB = 27;

	// Reset values
	localparam logic CTRL_DIR_RST = 1'b0;
	localparam logic [15:0] FILTER_RST = 16'h0000;
	localparam logic [15:0] JOG_SPEED_RST = 16'h0000;
	localparam logic [15:0] ACCEL_RST = 16'h0000;
	localparam logic [15:0] DECEL_RST = 16'h0000;
	localparam logic [15:0] SCURVE_RST = 16'h0000;
	localparam logic [31:0] SOFT_MIN_RST = 32'h80000000;
	localparam logic [31:0] SOFT_MAX_RST = 32'h7FFFFFFF;

	// Program store geometry
	localparam int PROG_COUNT = 16;
	localparam int STEP_COUNT = 8;
	localparam int STEP_W = 3;
	localparam int MEM_W = 7;
	localparam int NUM_IN = 15;

	// Step opcodes
	localparam logic [3:0] OP_STOP = 4'h0;
	localparam logic [3:0] OP_SPEED = 4'h1;
	localparam logic [3:0] OP_RAMP = 4'h2;
	localparam logic [3:0] OP_MOVE = 4'h3;
	localparam logic [3:0] OP_WAIT = 4'h4;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_EXEC = 3'b001,
		ST_MOVING = 3'b010,
		ST_WAITING = 3'b011,
		ST_PAUSED = 3'b100
	} prjs_state_e;

	// External inputs, all filtered before use
	typedef struct packed {
		logic operation_mode_select;
		logic program_select_bit3;
		logic program_select_bit2;
		logic program_select_bit1;
		logic program_select_bit0;
		logic forward_start;
		logic reverse_start;
		logic pause_resume_input;
		logic clear_remaining_input;
		logic forward_limit_switch;
		logic reverse_limit_switch;
		logic program_wait_input_3;
		logic program_wait_input_2;
		logic program_wait_input_1;
		logic base_shutoff;
	} prjs_in_s;

	// Absolute travel command to the motion generator
	typedef struct packed {
		logic [31:0] target;
		logic [15:0] speed;
		logic [15:0] ramp;
	} prjs_move_s;

	// JOG request to the motion generator
	typedef struct packed {
		logic run;
		logic cw;
		logic [15:0] speed;
		logic [15:0] accel;
		logic [15:0] decel;
		logic [15:0] scurve;
	} prjs_jog_s;
endpackage

/* rtl/prjs_top.sv */
// Program run and JOG sequencer with AXI4-Lite register slave
// Notes on behaviour
// - Mode select on gives program operation, off gives manual operation.
// - In program mode forward start runs the program picked by four select bits.
// - Reverse start is ignored in program mode.
// - Every external input is delayed by the programmable filter time.
// - Pause during a move halts using the running move's ramp.
// - A paused move resumes only on a fresh rising edge of pause.
// - Forward start does nothing while paused.
// - Leaving program mode while paused discards remaining travel and ends the program.
// - Pause is ignored during JOG and during home return; here HOME_ACTIVE gates only JOG, so a pause edge still halts a program move.
// - Clear while paused discards remaining travel; only forward start restarts.
// - The stop step ends the program; next start runs from step one.
// - Leaving program mode ends the program; restart needs program mode and start.
// - Hardware limit ends the program; restart needs both limits on then start.
// - Soft limit ends the program; restart needs position back in range.
// - Base shut-off ends the program; restart needs it cleared then start.
// - A wait step holds until its numbered program input is on.
// - Speed and ramp steps set values used by later absolute moves.
// - Program select bits are ignored in manual mode.
// - Direction setting 0 makes forward CCW, reverse CW; 1 swaps them.
// - JOG turns at JOG speed while a start input is held.
// - JOG uses its own accel, decel and S-curve settings.
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module prjs_top import prjs_pkg::*; (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// AXI4-Lite write address
	input wire logic [11:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	// AXI4-Lite write data
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	// AXI4-Lite write response
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// AXI4-Lite read address
	input wire logic [11:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	// AXI4-Lite read data
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// External inputs
	input wire prjs_pkg::prjs_in_s DIN,
	input wire logic HOME_ACTIVE,
	input wire logic [31:0] POSITION,
	// Motion generator side
	output prjs_pkg::prjs_move_s MOVE_CMD,
	output logic MOVE_VALID,
	input wire logic MOVE_DONE,
	output logic HALT_REQ,
	output logic DISCARD,
	output prjs_pkg::prjs_jog_s JOG,
	// Status
	output logic RUNNING,
	output logic PAUSED,
	output logic WAITING,
	output logic PROG_END
);
	// Control registers
	logic dir_sel_q;
	logic [15:0] filter_q;
	logic [15:0] jog_speed_q, accel_q, decel_q, scurve_q;
	logic [31:0] soft_min_q, soft_max_q;
	logic [31:0] prog_mem [0:PROG_COUNT*STEP_COUNT-1];

	// Input filter
	logic [NUM_IN-1:0] raw_in, filt_q;
	prjs_pkg::prjs_in_s fin, fin_prev_q;

	assign raw_in = DIN;

	// Output follows input only after it has held steady for the filter time
	genvar gi;
	generate
		for (gi = 0; gi < NUM_IN; gi++) begin : g_filt
			logic [15:0] cnt_q;
			always_ff @(posedge CLK_SYS) begin
				if (RST) begin
					cnt_q <= 16'h0000;
					filt_q[gi] <= 1'b0;
				end else if (raw_in[gi] == filt_q[gi]) begin
					cnt_q <= 16'h0000;
				end else if (cnt_q >= filter_q) begin
					cnt_q <= 16'h0000;
					filt_q[gi] <= raw_in[gi];
				end else begin
					cnt_q <= cnt_q + 16'h0001;
				end
			end
		end
	endgenerate

	assign fin = filt_q;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			fin_prev_q <= '0;
		end else begin
			fin_prev_q <= fin;
		end
	end

	// Edges and derived conditions
	logic prog_mode, start_edge, pause_edge, limits_ok, soft_ok, start_ok;
	assign prog_mode = fin.operation_mode_select;
	assign start_edge = fin.forward_start & ~fin_prev_q.forward_start;
	assign pause_edge = fin.pause_resume_input & ~fin_prev_q.pause_resume_input;
	assign limits_ok = fin.forward_limit_switch & fin.reverse_limit_switch;
	assign soft_ok = ($signed(POSITION) >= $signed(soft_min_q)) &&
		($signed(POSITION) <= $signed(soft_max_q));
	// Each restart gate checks the condition that ended the last run
	assign start_ok = prog_mode & start_edge & limits_ok & soft_ok & ~fin.base_shutoff;

	// Sequencer
	prjs_state_e state_q;
	logic [3:0] prog_sel_q;
	logic [STEP_W-1:0] step_q;
	logic [15:0] speed_q, ramp_q;
	logic [31:0] step_word;
	logic [3:0] step_op;
	logic [1:0] wait_idx;
	logic wait_hit, fault_end;

	assign step_word = prog_mem[{prog_sel_q, step_q}];
	assign step_op = step_word[STEP_OP_MSB:STEP_OP_LSB];
	assign wait_idx = step_word[1:0];
	always_comb begin
		case (wait_idx)
			2'h1: wait_hit = fin.program_wait_input_1;
			2'h2: wait_hit = fin.program_wait_input_2;
			2'h3: wait_hit = fin.program_wait_input_3;
			default: wait_hit = 1'b1;
		endcase
	end

	// Conditions that end a running program in any active state
	assign fault_end = ~prog_mode | ~limits_ok | ~soft_ok | fin.base_shutoff;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			state_q <= ST_IDLE;
			prog_sel_q <= 4'h0;
			step_q <= '0;
			speed_q <= 16'h0000;
			ramp_q <= 16'h0000;
			MOVE_CMD <= '0;
			MOVE_VALID <= 1'b0;
			HALT_REQ <= 1'b0;
			DISCARD <= 1'b0;
			PROG_END <= 1'b0;
		end else begin
			MOVE_VALID <= 1'b0;
			DISCARD <= 1'b0;
			PROG_END <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					// Reverse start is never looked at here
					if (start_ok) begin
						state_q <= ST_EXEC;
						prog_sel_q <= {fin.program_select_bit3, fin.program_select_bit2,
							fin.program_select_bit1, fin.program_select_bit0};
						step_q <= '0;
					end
				end
				ST_EXEC: begin
					if (fault_end) begin
						state_q <= ST_IDLE;
						step_q <= '0;
						PROG_END <= 1'b1;
					end else begin
						case (step_op)
							OP_SPEED: begin
								speed_q <= step_word[15:0];
								step_q <= step_q + 1'b1;
							end
							OP_RAMP: begin
								ramp_q <= step_word[15:0];
								step_q <= step_q + 1'b1;
							end
							OP_MOVE: begin
								MOVE_CMD.target <= {{4{step_word[STEP_ARG_MSB]}},
									step_word[STEP_ARG_MSB:0]};
								MOVE_CMD.speed <= speed_q;
								MOVE_CMD.ramp <= ramp_q;
								MOVE_VALID <= 1'b1;
								state_q <= ST_MOVING;
							end
							OP_WAIT: begin
								state_q <= ST_WAITING;
							end
							default: begin
								// Stop step, or any undefined opcode
								state_q <= ST_IDLE;
								step_q <= '0;
								PROG_END <= 1'b1;
							end
						endcase
						if (step_op != OP_MOVE && step_op != OP_WAIT &&
							step_op != OP_STOP && step_q == STEP_W'(STEP_COUNT-1)) begin
							state_q <= ST_IDLE;
							step_q <= '0;
							PROG_END <= 1'b1;
						end
					end
				end
				ST_MOVING: begin
					if (fault_end) begin
						state_q <= ST_IDLE;
						step_q <= '0;
						DISCARD <= 1'b1;
						PROG_END <= 1'b1;
					end else if (pause_edge) begin
						// Generator halts on the ramp of the move in flight
						state_q <= ST_PAUSED;
						HALT_REQ <= 1'b1;
					end else if (MOVE_DONE) begin
						state_q <= (step_q == STEP_W'(STEP_COUNT-1)) ? ST_IDLE : ST_EXEC;
						PROG_END <= (step_q == STEP_W'(STEP_COUNT-1));
						step_q <= step_q + 1'b1;
					end
				end
				ST_WAITING: begin
					if (fault_end) begin
						state_q <= ST_IDLE;
						step_q <= '0;
						PROG_END <= 1'b1;
					end else if (wait_hit) begin
						state_q <= (step_q == STEP_W'(STEP_COUNT-1)) ? ST_IDLE : ST_EXEC;
						PROG_END <= (step_q == STEP_W'(STEP_COUNT-1));
						step_q <= step_q + 1'b1;
					end
				end
				ST_PAUSED: begin
					// Forward start is deliberately not examined while halted
					if (fault_end || fin.clear_remaining_input) begin
						state_q <= ST_IDLE;
						step_q <= '0;
						HALT_REQ <= 1'b0;
						DISCARD <= 1'b1;
						PROG_END <= 1'b1;
					end else if (pause_edge) begin
						state_q <= ST_MOVING;
						HALT_REQ <= 1'b0;
					end
				end
				default: begin
					state_q <= ST_IDLE;
					step_q <= '0;
					HALT_REQ <= 1'b0;
				end
			endcase
		end
	end

	assign RUNNING = (state_q != ST_IDLE);
	assign PAUSED = (state_q == ST_PAUSED);
	assign WAITING = (state_q == ST_WAITING);

	// JOG: manual mode only, pause input has no path in here
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			JOG <= '0;
		end else begin
			JOG.speed <= jog_speed_q;
			JOG.accel <= accel_q;
			JOG.decel <= decel_q;
			JOG.scurve <= scurve_q;
			// Both starts held together is treated as a stop
			JOG.run <= ~prog_mode & ~HOME_ACTIVE & (state_q == ST_IDLE) &
				(fin.forward_start ^ fin.reverse_start);
			JOG.cw <= fin.forward_start ? dir_sel_q : ~dir_sel_q;
		end
	end

	// AXI4-Lite write path: address and data taken in either order
	logic aw_have_q, w_have_q;
	logic [11:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic do_write, wr_map_ok;
	logic [31:0] wr_mask;

	assign S_AXI_AWREADY = ~aw_have_q & ~S_AXI_BVALID;
	assign S_AXI_WREADY = ~w_have_q & ~S_AXI_BVALID;
	assign do_write = aw_have_q & w_have_q & ~S_AXI_BVALID;
	assign wr_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

	always_comb begin
		if (aw_addr_q == OFF_CTRL || aw_addr_q == OFF_FILTER ||
			aw_addr_q == OFF_JOG_SPEED || aw_addr_q == OFF_ACCEL ||
			aw_addr_q == OFF_DECEL || aw_addr_q == OFF_SCURVE ||
			aw_addr_q == OFF_SOFT_MIN || aw_addr_q == OFF_SOFT_MAX) begin
			wr_map_ok = 1'b1;
		end else if (aw_addr_q >= OFF_PROG_BASE && aw_addr_q <= OFF_PROG_LAST) begin
			wr_map_ok = 1'b1;
		end else begin
			wr_map_ok = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 12'h000;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= {S_AXI_AWADDR[11:2], 2'b00};
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_have_q <= 1'b1;
				w_data_q <= S_AXI_WDATA;
				w_strb_q <= S_AXI_WSTRB;
			end
			if (do_write) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_map_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// Register storage; writes only land on a completed handshake
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			dir_sel_q <= CTRL_DIR_RST;
			filter_q <= FILTER_RST;
			jog_speed_q <= JOG_SPEED_RST;
			accel_q <= ACCEL_RST;
			decel_q <= DECEL_RST;
			scurve_q <= SCURVE_RST;
			soft_min_q <= SOFT_MIN_RST;
			soft_max_q <= SOFT_MAX_RST;
		end else if (do_write) begin
			if (aw_addr_q == OFF_CTRL && w_strb_q[0]) begin
				dir_sel_q <= w_data_q[CTRL_DIR_BIT];
			end else if (aw_addr_q == OFF_FILTER) begin
				filter_q <= (filter_q & ~wr_mask[15:0]) | (w_data_q[15:0] & wr_mask[15:0]);
			end else if (aw_addr_q == OFF_JOG_SPEED) begin
				jog_speed_q <= (jog_speed_q & ~wr_mask[15:0]) | (w_data_q[15:0] & wr_mask[15:0]);
			end else if (aw_addr_q == OFF_ACCEL) begin
				accel_q <= (accel_q & ~wr_mask[15:0]) | (w_data_q[15:0] & wr_mask[15:0]);
			end else if (aw_addr_q == OFF_DECEL) begin
				decel_q <= (decel_q & ~wr_mask[15:0]) | (w_data_q[15:0] & wr_mask[15:0]);
			end else if (aw_addr_q == OFF_SCURVE) begin
				scurve_q <= (scurve_q & ~wr_mask[15:0]) | (w_data_q[15:0] & wr_mask[15:0]);
			end else if (aw_addr_q == OFF_SOFT_MIN) begin
				soft_min_q <= (soft_min_q & ~wr_mask) | (w_data_q & wr_mask);
			end else if (aw_addr_q == OFF_SOFT_MAX) begin
				soft_max_q <= (soft_max_q & ~wr_mask) | (w_data_q & wr_mask);
			end
		end
	end

	// Program store has no reset; software loads it before first start
	always_ff @(posedge CLK_SYS) begin
		if (do_write && aw_addr_q >= OFF_PROG_BASE && aw_addr_q <= OFF_PROG_LAST) begin
			prog_mem[aw_addr_q[8:2]] <= (prog_mem[aw_addr_q[8:2]] & ~wr_mask) |
				(w_data_q & wr_mask);
		end
	end

	// AXI4-Lite read path, one cycle from address to data
	logic [11:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_ok;

	assign S_AXI_ARREADY = ~S_AXI_RVALID;
	assign rd_addr = {S_AXI_ARADDR[11:2], 2'b00};

	always_comb begin
		rd_ok = 1'b1;
		rd_data = 32'h00000000;
		if (rd_addr == OFF_CTRL) begin
			rd_data[CTRL_DIR_BIT] = dir_sel_q;
		end else if (rd_addr == OFF_FILTER) begin
			rd_data[15:0] = filter_q;
		end else if (rd_addr == OFF_JOG_SPEED) begin
			rd_data[15:0] = jog_speed_q;
		end else if (rd_addr == OFF_ACCEL) begin
			rd_data[15:0] = accel_q;
		end else if (rd_addr == OFF_DECEL) begin
			rd_data[15:0] = decel_q;
		end else if (rd_addr == OFF_SCURVE) begin
			rd_data[15:0] = scurve_q;
		end else if (rd_addr == OFF_SOFT_MIN) begin
			rd_data = soft_min_q;
		end else if (rd_addr == OFF_SOFT_MAX) begin
			rd_data = soft_max_q;
		end else if (rd_addr == OFF_STATUS) begin
			rd_data = {6'h00, prog_sel_q, step_q, 1'b0, state_q, filt_q[NUM_IN-1:3],
				PAUSED, WAITING, RUNNING};
		end else if (rd_addr >= OFF_PROG_BASE && rd_addr <= OFF_PROG_LAST) begin
			rd_data = prog_mem[rd_addr[8:2]];
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= rd_data;
			S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end
endmodule // prjs_top

/* testbench/prjs_top_asserts.sv */
// Port-level assertions for the sequencer top
`timescale 1ns/1ps
module prjs_top_asserts (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// Bus answers
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Sequencer outputs
	input wire logic MOVE_VALID,
	input wire logic HALT_REQ,
	input wire logic DISCARD,
	input wire prjs_pkg::prjs_jog_s JOG,
	input wire logic RUNNING,
	input wire logic PAUSED,
	input wire logic WAITING,
	input wire logic PROG_END
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);

	AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped");
	AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped");
	AST_AR_READY: assert property (S_AXI_ARREADY == !S_AXI_RVALID)
		else $error("read address ready wrong");
	AST_MOVE_PULSE: assert property (MOVE_VALID |=> !MOVE_VALID && RUNNING)
		else $error("move command not a single pulse");
	AST_MOVE_RUN: assert property (MOVE_VALID |-> RUNNING && !PAUSED && !WAITING)
		else $error("move issued outside running");
	AST_HALT_PAUSED: assert property (HALT_REQ |-> PAUSED)
		else $error("halt without pause");
	AST_PAUSE_ENTRY: assert property ($rose(PAUSED) |-> HALT_REQ && !MOVE_VALID)
		else $error("pause entered without halt");
	AST_DISCARD_END: assert property (DISCARD |-> ##[0:1] PROG_END)
		else $error("discard without program end");
	AST_END_CLEAR: assert property (PROG_END |-> !PAUSED && !WAITING && !HALT_REQ)
		else $error("end left wait or pause");
	AST_END_ONCE: assert property (PROG_END |=> !PROG_END)
		else $error("program end not a pulse");
	AST_JOG_IDLE: assert property (JOG.run |-> !RUNNING && !PAUSED)
		else $error("jog during program");

	COV_MOVE: cover property (MOVE_VALID);
	COV_PAUSE: cover property ($rose(PAUSED));
	COV_DISCARD: cover property (DISCARD);
	COV_JOG: cover property (JOG.run);
endmodule // prjs_top_asserts

bind prjs_top prjs_top_asserts u_asserts (
	.CLK_SYS(CLK_SYS),
	.RST(RST),
	.S_AXI_BRESP(S_AXI_BRESP),
	.S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY),
	.S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_RREADY(S_AXI_RREADY),
	.MOVE_VALID(MOVE_VALID),
	.HALT_REQ(HALT_REQ),
	.DISCARD(DISCARD),
	.JOG(JOG),
	.RUNNING(RUNNING),
	.PAUSED(PAUSED),
	.WAITING(WAITING),
	.PROG_END(PROG_END)
);

/* testbench/prjs_motion_model.sv */
// Motion generator stand-in finishing moves after a set delay
`timescale 1ns/1ps
module prjs_motion_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Commands
	input wire logic move_valid,
	input wire logic halt_req,
	input wire logic discard,
	input wire logic [7:0] lat,
	// Completion
	output logic move_done
);
	logic busy_q;
	logic [7:0] cnt_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			busy_q <= 1'b0;
			cnt_q <= 8'h00;
			move_done <= 1'b0;
		end else begin
			move_done <= 1'b0;
			if (move_valid) begin
				busy_q <= 1'b1;
				cnt_q <= lat;
			end else if (discard) begin
				busy_q <= 1'b0;
			end else if (busy_q && !halt_req) begin // Distance frozen while halted
				if (cnt_q == 8'h00) begin
					busy_q <= 1'b0;
					move_done <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 8'h01;
				end
			end
		end
	end
endmodule // prjs_motion_model

/* testbench/prjs_top_bench.sv */
// Self-checking bench for the program run and jog sequencer
`timescale 1ns/1ps
module prjs_top_bench;
	typedef struct {
		logic [11:0] addr;
		logic [31:0] data;
		logic [1:0] resp;
	} prjs_row_s;
	localparam logic [1:0] OK = prjs_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = prjs_pkg::RESP_SLVERR;
	logic clk, rst, awvalid, wvalid, bready, arvalid, rready, home, mdone;
	logic awready, wready, bvalid, arready, rvalid, mvalid, halt, disc, run, paused, waiting, pend;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, pos, d;
	logic [1:0] bresp, rresp, r;
	logic [7:0] lat;
	prjs_pkg::prjs_in_s din;
	prjs_pkg::prjs_move_s mcmd;
	prjs_pkg::prjs_jog_s jog;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [31:0] prog_w [7] = '{{prjs_pkg::OP_SPEED, 28'h0000100}, {prjs_pkg::OP_RAMP, 28'h0000020},
		{prjs_pkg::OP_MOVE, 28'hFFFFFF0}, {prjs_pkg::OP_WAIT, 28'h0000001},
		{prjs_pkg::OP_RAMP, 28'h0000030}, {prjs_pkg::OP_MOVE, 28'h0000100},
		{prjs_pkg::OP_STOP, 28'h0000000}};
	prjs_row_s rows [6] = '{'{prjs_pkg::OFF_CTRL, 32'h0, OK}, '{prjs_pkg::OFF_FILTER, 32'h3, OK},
		'{prjs_pkg::OFF_JOG_SPEED, 32'h1234, OK}, '{prjs_pkg::OFF_SOFT_MIN, 32'h80000000, OK},
		'{prjs_pkg::OFF_SOFT_MAX, 32'h800, OK}, '{12'h104, 32'h0, ERR}};

	prjs_top uut (
		.CLK_SYS(clk), .RST(rst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.DIN(din), .HOME_ACTIVE(home), .POSITION(pos),
		.MOVE_CMD(mcmd), .MOVE_VALID(mvalid), .MOVE_DONE(mdone), .HALT_REQ(halt),
		.DISCARD(disc), .JOG(jog), .RUNNING(run), .PAUSED(paused), .WAITING(waiting),
		.PROG_END(pend)
	);
	prjs_motion_model u_motion (.clk(clk), .rst(rst), .move_valid(mvalid), .halt_req(halt),
		.discard(disc), .lat(lat), .move_done(mdone));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task finish_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			finish_test();
		end
	end

	task check(input string nm, input logic [65:0] seen, input logic [65:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
		int n;
		logic pa, pw;
		n = 0;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			n++;
			if ((!pa && !pw && bvalid) || n > 100) break;
			if (pa && awready) begin
				pa = 1'b0;
				awvalid <= 1'b0;
			end
			if (pw && wready) begin
				pw = 1'b0;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b0;
		check("bresp", {64'h0, bresp}, {64'h0, er});
	endtask

	task rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rr);
		int n;
		logic pa;
		n = 0;
		pa = 1'b1;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			n++;
			if ((!pa && rvalid) || n > 100) break;
			if (pa && arready) begin
				pa = 1'b0;
				arvalid <= 1'b0;
			end
		end
		v = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask

	// Waits on a design output under a bound; 0 move, 1 end, 2 pause, 3 wait
	task wait_sig(input int k);
		int n;
		logic s;
		n = 0;
		s = 1'b0;
		while (s !== 1'b1 && n < 400) begin
			@(posedge clk);
			#1;
			n++;
			case (k)
				0: s = mvalid;
				1: s = pend;
				2: s = paused;
				default: s = waiting;
			endcase
		end
		check("wait", {65'h0, s}, 66'h1);
	endtask

	task go;
		tick(1);
		din.forward_start <= 1'b0;
		tick(12);
		din.forward_start <= 1'b1;
		wait_sig(0);
	endtask

	task fault(input int k, input logic v);
		case (k)
			0: din.forward_limit_switch <= !v;
			1: din.base_shutoff <= v;
			default: pos <= v ? 32'h1000 : 32'h0;
		endcase
	endtask

	initial begin
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, home} = '0;
		{awaddr, araddr, wdata, pos} = '0;
		din = '0;
		lat = 8'h04;
		tick(2);
		rst <= 1'b0;
		din.forward_limit_switch <= 1'b1;
		din.reverse_limit_switch <= 1'b1;
		wr(prjs_pkg::OFF_FILTER, 32'h3, OK);
		wr(prjs_pkg::OFF_JOG_SPEED, 32'h1234, OK);
		wr(prjs_pkg::OFF_SOFT_MAX, 32'h800, OK);
		wr(12'h104, 32'hFFFF, ERR);
		for (int i = 0; i < 7; i++) wr(12'h2A0 + 12'(i * 4), prog_w[i], OK);
		foreach (rows[i]) begin
			rd(rows[i].addr, d, r);
			check("reg data", {34'h0, d}, {34'h0, rows[i].data});
			check("reg resp", {64'h0, r}, {64'h0, rows[i].resp});
		end
		tick(1);
		din.operation_mode_select <= 1'b1;
		din.program_select_bit2 <= 1'b1;
		din.program_select_bit0 <= 1'b1;
		din.reverse_start <= 1'b1;
		tick(30);
		check("reverse start", {65'h0, run}, 66'h0);
		din.reverse_start <= 1'b0;
		din.forward_start <= 1'b1;
		wait_sig(0);
		check("move1", mcmd, {32'hFFFFFFF0, 16'h0100, 16'h0020});
		wait_sig(3);
		tick(20);
		check("still waiting", {65'h0, waiting}, 66'h1);
		din.program_wait_input_1 <= 1'b1;
		wait_sig(0);
		check("move2", mcmd, {32'h00000100, 16'h0100, 16'h0030});
		wait_sig(1);
		tick(1);
		din.program_wait_input_1 <= 1'b0;
		lat <= 8'hC8;
		go();
		check("restart", mcmd, {32'hFFFFFFF0, 16'h0100, 16'h0020});
		tick(1);
		din.pause_resume_input <= 1'b1;
		wait_sig(2);
		check("halt", {65'h0, halt}, 66'h1);
		tick(1);
		din.forward_start <= 1'b0;
		tick(12);
		din.forward_start <= 1'b1;
		din.pause_resume_input <= 1'b0;
		tick(20);
		check("paused", {64'h0, paused, halt}, 66'h3);
		din.pause_resume_input <= 1'b1;
		tick(20);
		check("resumed", {63'h0, run, paused, halt}, 66'h4);
		din.pause_resume_input <= 1'b0;
		tick(12);
		din.pause_resume_input <= 1'b1;
		wait_sig(2);
		tick(1);
		din.clear_remaining_input <= 1'b1;
		wait_sig(1);
		tick(1);
		din.clear_remaining_input <= 1'b0;
		din.pause_resume_input <= 1'b0;
		tick(12);
		din.pause_resume_input <= 1'b1;
		tick(20);
		check("no restart", {65'h0, run}, 66'h0);
		din.pause_resume_input <= 1'b0;
		go();
		tick(1);
		din.pause_resume_input <= 1'b1;
		wait_sig(2);
		tick(1);
		din.operation_mode_select <= 1'b0;
		wait_sig(1);
		tick(1);
		din.operation_mode_select <= 1'b1;
		din.pause_resume_input <= 1'b0;
		tick(12);
		din.pause_resume_input <= 1'b1;
		tick(20);
		check("mode cleared", {65'h0, run}, 66'h0);
		din.pause_resume_input <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			go();
			tick(1);
			fault(k, 1'b1);
			wait_sig(1);
			tick(1);
			din.forward_start <= 1'b0;
			tick(12);
			din.forward_start <= 1'b1;
			tick(20);
			check("fault blocks", {65'h0, run}, 66'h0);
			fault(k, 1'b0);
			go();
			tick(1);
			din.operation_mode_select <= 1'b0;
			wait_sig(1);
			tick(1);
			din.operation_mode_select <= 1'b1;
		end
		din.operation_mode_select <= 1'b0;
		din.forward_start <= 1'b0;
		wr(prjs_pkg::OFF_ACCEL, 32'h11, OK);
		wr(prjs_pkg::OFF_DECEL, 32'h22, OK);
		for (int dr = 0; dr < 2; dr++) begin
			wr(prjs_pkg::OFF_CTRL, 32'(dr), OK);
			for (int rv = 0; rv < 2; rv++) begin
				tick(1);
				din.forward_start <= (rv == 0);
				din.reverse_start <= (rv == 1);
				din.pause_resume_input <= 1'b1;
				tick(12);
				check("jog", {jog.run, jog.cw, jog.speed, jog.accel, jog.decel},
					{1'b1, 1'(dr ^ rv), 48'h123400110022});
				check("jog pause", {65'h0, paused}, 66'h0);
				din.forward_start <= 1'b0;
				din.reverse_start <= 1'b0;
				din.pause_resume_input <= 1'b0;
				tick(12);
				check("jog stop", {65'h0, jog.run}, 66'h0);
			end
		end
		finish_test();
	end
endmodule // prjs_top_bench
